// ---- switch_sense_model.sv ----
/*
   Model of the power switch, current ramp and zero-crossing comparators.
   Assumes the bench sets on length, ringing level, crossing count and overvoltage.
*/
module switch_sense_model (
   input wire logic clk_in,
   input wire logic gate_in,
   input wire logic [15:0] on_len_in,
   input wire logic ring_hi_in,
   input wire logic [3:0] n_cross_in,
   input wire logic ovp_cmd_in,
   output logic cs_trip_out,
   output logic det_out,
   output logic ring_out,
   output logic ovp_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] on_ff = 16'h0;
   logic [15:0] off_ff = 16'h0;
   logic cs_ff = 1'b0;
   logic det_ff = 1'b0;
   logic ring_ff = 1'b0;
   logic ovp_ff = 1'b0;
   // ==========================================================
   // Comparator outputs, idle low from time zero
   assign cs_trip_out = cs_ff;
   assign det_out = det_ff;
   assign ring_out = ring_ff;
   assign ovp_out = ovp_ff;
   // ==========================================================
   // Current ramp, ringing and overvoltage
   always @(posedge clk_in) begin
      on_ff <= gate_in ? on_ff + 16'h1 : 16'h0;
      off_ff <= gate_in ? 16'h0 : off_ff + 16'h1;
      cs_ff <= gate_in && (on_ff >= on_len_in);
      det_ff <= !gate_in && (off_ff < 16'h32 * n_cross_in) && (off_ff % 16'h32 < 16'h19);
      ring_ff <= ring_hi_in;
      ovp_ff <= !gate_in && ovp_cmd_in;
   end
endmodule

// ---- valley_qr_pkg.sv ----
/*
   Constants for the valley-switching quasi-resonant control core.
   Assumes a 125 MHz core clock.
*/
package valley_qr_pkg;
   // ==========================================================
   // Clock
   localparam int unsigned CLK_PERIOD_NS = 8;

   // ==========================================================
   // Soft-start
   localparam int unsigned SOFTSTART_MS = 12;
   localparam int unsigned SS_STEPS = 4;
   localparam logic [1:0] SS_STEP_FIRST = 2'h0;
   localparam logic [1:0] SS_STEP_LAST = 2'h3;
   localparam int unsigned SS_FIRST_MV = 320;
   localparam int unsigned SS_LAST_MV = 1000;
   localparam int unsigned SS_STEP_CYCLES = (SOFTSTART_MS * 1000000) / (SS_STEPS * CLK_PERIOD_NS);

   // ==========================================================
   // Valley counter
   localparam int unsigned COUNT_PERIOD_MS = 48;
   localparam int unsigned COUNT_PERIOD_CYCLES = (COUNT_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
   localparam logic [2:0] VALLEY_MIN = 3'h1;
   localparam logic [2:0] VALLEY_MAX = 3'h7;
   localparam logic [2:0] CROSS_MIN = 3'h0;
   localparam logic [2:0] CROSS_MAX = 3'h7;
   localparam int unsigned CROSS_DET_MV = 100;

   // ==========================================================
   // Switching times
   localparam int unsigned LEB_NS = 220;
   localparam int unsigned RING_SHORT_NS = 2000;
   localparam int unsigned RING_LONG_NS = 25000;
   localparam int unsigned MAX_OFF_NS = 50000;
   localparam int unsigned OVP_BLANK_NS = 1000;
   localparam int unsigned LEB_CYCLES = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RING_SHORT_CYCLES = (RING_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RING_LONG_CYCLES = (RING_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MAX_OFF_CYCLES = (MAX_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OVP_BLANK_CYCLES = (OVP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Synchroniser bit positions
   localparam int unsigned SYNC_W = 9;
   localparam int unsigned IX_SUPPLY = 0;
   localparam int unsigned IX_FB_UP = 1;
   localparam int unsigned IX_FB_DOWN = 2;
   localparam int unsigned IX_FB_RESET = 3;
   localparam int unsigned IX_CROSS = 4;
   localparam int unsigned IX_OVP = 5;
   localparam int unsigned IX_RING = 6;
   localparam int unsigned IX_CS = 7;
   localparam int unsigned IX_LINE = 8;

   // ==========================================================
   // Switching states
   typedef enum logic [4:0] {
      ST_WAIT = 5'h01,
      ST_SUPPRESS = 5'h02,
      ST_OFF_WAIT = 5'h04,
      ST_ON = 5'h08,
      ST_LATCHED = 5'h10
   } sw_state_t;
endpackage

// ---- valley_switch_frequency_reduction.sv ----
/*
   Valley-switching frequency reduction core: soft-start, valley counter,
   zero-crossing counter, gate timing and overvoltage latch.
   Assumes analog comparator outputs arrive asynchronously and the supply
   turn-on event is seen on supply_on_in.
*/
// Notes on behaviour
// - Supply turn-on disables the start-up cell and starts soft-start.
// - Peak current limit rises in four steps over the soft-start time.
// - Feedback thresholds are evaluated and the valley counter updated each period.
// - Per period: below up increments, mid holds, above down decrements, above reset sets one.
// - Valley counter saturates between one and seven.
// - Valley counter starts at one.
// - Feedback threshold set follows the detected line level.
// - Valley counter gives the zero crossing at which the switch turns on.
// - Turn-on from digital counters; turn-off from the current comparator.
// - Zero-crossing counter holds zero to seven and never wraps.
// - Each falling zero crossing after turn-off adds one to the crossing counter.
// - Crossing counter clears whenever the gate goes high.
// - Overvoltage while off latches the gate off after a blanking delay.
// - After suppression, turn on once crossings reach the valley count.
// - Gate off for the maximum off time forces turn-on.
// - Suppression is long when the crossing input is below ringing level, else short.
// - Turn-off comparator ignored for the blanking time after turn-on.
module valley_switch_frequency_reduction
   import valley_qr_pkg::*;
#(
   parameter int unsigned SS_STEP_LEN = SS_STEP_CYCLES,
   parameter int unsigned COUNT_PERIOD_LEN = COUNT_PERIOD_CYCLES,
   parameter int unsigned MAX_OFF_LEN = MAX_OFF_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic supply_on_in,
   input wire logic fb_level_above_up_in,
   input wire logic fb_level_above_down_in,
   input wire logic fb_level_above_reset_in,
   input wire logic zero_cross_input_det_in,
   input wire logic zero_cross_input_ovp_in,
   input wire logic zero_cross_input_ring_in,
   input wire logic cs_trip_in,
   input wire logic line_high_in,
   output logic gate_output_out,
   output logic startup_cell_en_out,
   output logic [1:0] cs_limit_step_out,
   output logic threshold_sel_out,
   output logic [2:0] valley_count_out,
   output logic latched_off_out
);
   // ==========================================================
   // Input synchronisers
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] sync1_ff;
   logic [SYNC_W-1:0] sync2_ff;
   logic cross_prev_ff;
   logic cross_event;

   assign raw_in = {line_high_in, cs_trip_in, zero_cross_input_ring_in, zero_cross_input_ovp_in,
                    zero_cross_input_det_in, fb_level_above_reset_in, fb_level_above_down_in,
                    fb_level_above_up_in, supply_on_in};

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         cross_prev_ff <= 1'b0;
      end else begin
         sync1_ff <= raw_in;
         sync2_ff <= sync1_ff;
         cross_prev_ff <= sync2_ff[IX_CROSS];
      end
   end

   assign cross_event = cross_prev_ff & ~sync2_ff[IX_CROSS];

   // ==========================================================
   // Switching state machine
   sw_state_t state_ff;
   sw_state_t nxt_state;
   logic [31:0] off_cnt_ff;
   logic [31:0] on_cnt_ff;
   logic [31:0] ovp_cnt_ff;
   logic ring_long_ff;
   logic [2:0] cross_cnt_ff;
   logic [2:0] valley_ff;
   logic is_off;
   logic ovp_trip;
   logic max_off_hit;
   logic ring_done;
   logic valley_hit;
   logic leb_done;

   assign is_off = (state_ff == ST_SUPPRESS) || (state_ff == ST_OFF_WAIT);
   assign ovp_trip = is_off && sync2_ff[IX_OVP] && (ovp_cnt_ff >= OVP_BLANK_CYCLES - 1);
   assign max_off_hit = off_cnt_ff >= MAX_OFF_LEN - 1;
   assign ring_done = ring_long_ff ? (off_cnt_ff >= RING_LONG_CYCLES - 1)
                                   : (off_cnt_ff >= RING_SHORT_CYCLES - 1);
   assign valley_hit = cross_cnt_ff >= valley_ff;
   assign leb_done = on_cnt_ff >= LEB_CYCLES - 1;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_WAIT: begin
            if (sync2_ff[IX_SUPPLY]) begin
               nxt_state = ST_SUPPRESS;
            end
         end
         ST_SUPPRESS: begin
            if (ovp_trip) begin
               nxt_state = ST_LATCHED;
            end else if (max_off_hit) begin
               nxt_state = ST_ON;
            end else if (ring_done) begin
               nxt_state = ST_OFF_WAIT;
            end
         end
         ST_OFF_WAIT: begin
            if (ovp_trip) begin
               nxt_state = ST_LATCHED;
            end else if (valley_hit || max_off_hit) begin
               nxt_state = ST_ON;
            end
         end
         ST_ON: begin
            if (leb_done && sync2_ff[IX_CS]) begin
               nxt_state = ST_SUPPRESS;
            end
         end
         ST_LATCHED: begin
            nxt_state = ST_LATCHED;
         end
         default: begin
            nxt_state = ST_LATCHED;
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         state_ff <= ST_WAIT;
         gate_output_out <= 1'b0;
         latched_off_out <= 1'b0;
         startup_cell_en_out <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         gate_output_out <= (nxt_state == ST_ON);
         latched_off_out <= (nxt_state == ST_LATCHED);
         startup_cell_en_out <= (nxt_state == ST_WAIT);
      end
   end

   // ==========================================================
   // Off, on and overvoltage timers
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         off_cnt_ff <= 32'h0;
         on_cnt_ff <= 32'h0;
         ovp_cnt_ff <= 32'h0;
         ring_long_ff <= 1'b0;
      end else begin
         if (nxt_state == ST_SUPPRESS && state_ff != ST_SUPPRESS) begin
            off_cnt_ff <= 32'h0;
            ring_long_ff <= ~sync2_ff[IX_RING];
         end else if (is_off && !max_off_hit) begin
            off_cnt_ff <= off_cnt_ff + 32'h1;
         end
         if (state_ff != ST_ON) begin
            on_cnt_ff <= 32'h0;
         end else if (!leb_done) begin
            on_cnt_ff <= on_cnt_ff + 32'h1;
         end
         if (is_off && sync2_ff[IX_OVP] && !ovp_trip) begin
            ovp_cnt_ff <= ovp_cnt_ff + 32'h1;
         end else if (!(is_off && sync2_ff[IX_OVP])) begin
            ovp_cnt_ff <= 32'h0;
         end
      end
   end

   // ==========================================================
   // Zero-crossing counter
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         cross_cnt_ff <= CROSS_MIN;
      end else if (nxt_state == ST_ON && state_ff != ST_ON) begin
         cross_cnt_ff <= CROSS_MIN;
      end else if (is_off && cross_event && cross_cnt_ff != CROSS_MAX) begin
         cross_cnt_ff <= cross_cnt_ff + 3'h1;
      end
   end

   // ==========================================================
   // Valley counter
   logic running;
   logic [31:0] period_cnt_ff;
   logic period_tick;
   logic seen_up_ff;
   logic seen_down_ff;
   logic seen_reset_ff;
   logic any_up;
   logic any_down;
   logic any_reset;
   logic [2:0] nxt_valley;

   assign running = (state_ff != ST_WAIT);
   assign period_tick = running && (period_cnt_ff >= COUNT_PERIOD_LEN - 1);
   assign any_up = seen_up_ff | sync2_ff[IX_FB_UP];
   assign any_down = seen_down_ff | sync2_ff[IX_FB_DOWN];
   assign any_reset = seen_reset_ff | sync2_ff[IX_FB_RESET];
   assign nxt_valley = any_reset ? VALLEY_MIN :
                       any_down ? ((valley_ff == VALLEY_MIN) ? VALLEY_MIN : valley_ff - 3'h1) :
                       any_up ? valley_ff :
                       ((valley_ff == VALLEY_MAX) ? VALLEY_MAX : valley_ff + 3'h1);

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         period_cnt_ff <= 32'h0;
         seen_up_ff <= 1'b0;
         seen_down_ff <= 1'b0;
         seen_reset_ff <= 1'b0;
         valley_ff <= VALLEY_MIN;
      end else if (!running) begin
         period_cnt_ff <= 32'h0;
         seen_up_ff <= 1'b0;
         seen_down_ff <= 1'b0;
         seen_reset_ff <= 1'b0;
         valley_ff <= VALLEY_MIN;
      end else if (period_tick) begin
         period_cnt_ff <= 32'h0;
         seen_up_ff <= 1'b0;
         seen_down_ff <= 1'b0;
         seen_reset_ff <= 1'b0;
         valley_ff <= nxt_valley;
      end else begin
         period_cnt_ff <= period_cnt_ff + 32'h1;
         seen_up_ff <= any_up;
         seen_down_ff <= any_down;
         seen_reset_ff <= any_reset;
      end
   end

   // ==========================================================
   // Soft-start and threshold selection
   logic [31:0] ss_cnt_ff;
   logic ss_tick;

   assign ss_tick = running && (cs_limit_step_out != SS_STEP_LAST) && (ss_cnt_ff >= SS_STEP_LEN - 1);

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         ss_cnt_ff <= 32'h0;
         cs_limit_step_out <= SS_STEP_FIRST;
         threshold_sel_out <= 1'b0;
         valley_count_out <= VALLEY_MIN;
      end else begin
         threshold_sel_out <= sync2_ff[IX_LINE];
         valley_count_out <= valley_ff;
         if (!running || ss_tick) begin
            ss_cnt_ff <= 32'h0;
         end else if (cs_limit_step_out != SS_STEP_LAST) begin
            ss_cnt_ff <= ss_cnt_ff + 32'h1;
         end
         if (ss_tick) begin
            cs_limit_step_out <= cs_limit_step_out + 2'h1;
         end
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_turn_off;
      gate_output_out ##1 !gate_output_out;
   endsequence

   property p_valley_range;
      (valley_ff >= VALLEY_MIN) && (valley_ff <= VALLEY_MAX);
   endproperty
   a_valley_range: assert property (p_valley_range) else $error("Valley count out of range");

   property p_cross_clear;
      $rose(gate_output_out) |-> (cross_cnt_ff == CROSS_MIN);
   endproperty
   a_cross_clear: assert property (p_cross_clear) else $error("Crossing count not cleared");

   property p_cross_inc;
      (is_off && cross_event && cross_cnt_ff != CROSS_MAX && nxt_state != ST_ON)
         |=> (cross_cnt_ff == $past(cross_cnt_ff) + 3'h1);
   endproperty
   a_cross_inc: assert property (p_cross_inc) else $error("Crossing not counted");

   property p_min_on;
      (state_ff == ST_ON && on_cnt_ff < LEB_CYCLES - 1) |=> gate_output_out;
   endproperty
   a_min_on: assert property (p_min_on) else $error("Gate dropped inside blanking");

   property p_suppress;
      s_turn_off |-> !gate_output_out [*8];
   endproperty
   a_suppress: assert property (p_suppress) else $error("Gate rose during suppression");

   property p_max_off;
      (is_off && max_off_hit && !ovp_trip) |=> gate_output_out;
   endproperty
   a_max_off: assert property (p_max_off) else $error("Maximum off time not enforced");

   property p_latched;
      (state_ff == ST_LATCHED) |=> (state_ff == ST_LATCHED) && !gate_output_out;
   endproperty
   a_latched: assert property (p_latched) else $error("Latch released");

   property p_reset_valley;
      (period_tick && any_reset) |=> (valley_ff == VALLEY_MIN);
   endproperty
   a_reset_valley: assert property (p_reset_valley) else $error("Valley not set to one");

   property p_startup;
      (state_ff == ST_WAIT && sync2_ff[IX_SUPPLY]) |=> !startup_cell_en_out;
   endproperty
   a_startup: assert property (p_startup) else $error("Start-up cell left on");

   property p_turn_on;
      (state_ff == ST_OFF_WAIT && valley_hit && !ovp_trip) |=> gate_output_out;
   endproperty
   a_turn_on: assert property (p_turn_on) else $error("Missed valley turn-on");
endmodule

// ---- valley_switch_frequency_reduction_test.sv ----
/*
   Self-checking bench for the valley-switching core with shortened counts.
   Assumes the switch and comparator model drives the analog inputs.
*/
module valley_switch_frequency_reduction_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic supply_on = 1'b0;
   logic fb_up = 1'b0;
   logic fb_down = 1'b0;
   logic fb_reset = 1'b0;
   logic line_high = 1'b0;
   logic [15:0] on_len = 16'h28;
   logic ring_hi = 1'b1;
   logic [3:0] n_cross = 4'h8;
   logic ovp_cmd = 1'b0;
   logic cs_trip, det, ring, ovp, gate, cell_en, thr_sel, latched;
   logic [1:0] step;
   logic [2:0] valley;
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;
   int len;
   // ==========================================================
   // Clock, timeout and instances
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   valley_switch_frequency_reduction #(.SS_STEP_LEN(20), .COUNT_PERIOD_LEN(50), .MAX_OFF_LEN(400))
   i_valley_switch_frequency_reduction (.core_clk_in(core_clk), .rst_n_in(rst_n), .supply_on_in(supply_on),
      .fb_level_above_up_in(fb_up), .fb_level_above_down_in(fb_down), .fb_level_above_reset_in(fb_reset),
      .zero_cross_input_det_in(det), .zero_cross_input_ovp_in(ovp), .zero_cross_input_ring_in(ring),
      .cs_trip_in(cs_trip), .line_high_in(line_high), .gate_output_out(gate), .startup_cell_en_out(cell_en),
      .cs_limit_step_out(step), .threshold_sel_out(thr_sel), .valley_count_out(valley),
      .latched_off_out(latched));
   switch_sense_model i_switch_sense_model (.clk_in(core_clk), .gate_in(gate), .on_len_in(on_len),
      .ring_hi_in(ring_hi), .n_cross_in(n_cross), .ovp_cmd_in(ovp_cmd), .cs_trip_out(cs_trip),
      .det_out(det), .ring_out(ring), .ovp_out(ovp));
   // ==========================================================
   // Helpers
   task automatic tally_and_finish();
      if (num_errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_len(input int got, input int lo, input int hi);
      checks++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic span(input logic lvl, output int n);
      int w;
      w = 0;
      while (gate !== !lvl && w < 5000) begin
         tick(1);
         w++;
      end
      while (gate !== lvl && w < 5000) begin
         tick(1);
         w++;
      end
      n = 0;
      while (gate === lvl && n < 5000) begin
         tick(1);
         n++;
      end
   endtask
   task automatic set_fb(input logic up, input logic down, input logic rst);
      @(posedge core_clk);
      fb_up <= up;
      fb_down <= down;
      fb_reset <= rst;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      tick(2);
      check_val(gate, 8'h0);
      check_val(cell_en, 8'h1);
      check_val(step, 8'h0);
      check_val(valley, 8'h1);
      check_val(latched, 8'h0);
   endtask
   task automatic t_start();
      int n;
      @(posedge core_clk);
      supply_on <= 1'b1;
      n = 0;
      while (cell_en !== 1'b0 && n < 50) begin
         tick(1);
         n++;
      end
      check_len(n, 2, 5);
      tick(10);
      check_val(step, 8'h0);
      tick(20);
      check_val(step, 8'h1);
      tick(20);
      check_val(step, 8'h2);
      tick(20);
      check_val(step, 8'h3);
      tick(80);
      check_val(step, 8'h3);
   endtask
   task automatic t_line();
      @(posedge core_clk);
      line_high <= 1'b1;
      tick(5);
      check_val(thr_sel, 8'h1);
      @(posedge core_clk);
      line_high <= 1'b0;
      tick(5);
      check_val(thr_sel, 8'h0);
   endtask
   task automatic t_valley();
      int n;
      set_fb(1'b1, 1'b1, 1'b1);
      tick(150);
      check_val(valley, 8'h1);
      set_fb(1'b0, 1'b0, 1'b0);
      n = 0;
      while (valley !== 3'h3 && n < 400) begin
         tick(1);
         n++;
      end
      set_fb(1'b1, 1'b0, 1'b0);
      tick(150);
      check_val(valley, 8'h3);
      set_fb(1'b0, 1'b0, 1'b0);
      tick(400);
      check_val(valley, 8'h7);
      set_fb(1'b1, 1'b1, 1'b0);
      tick(400);
      check_val(valley, 8'h1);
      set_fb(1'b0, 1'b0, 1'b0);
      tick(400);
      set_fb(1'b1, 1'b1, 1'b1);
      tick(100);
      check_val(valley, 8'h1);
   endtask
   task automatic t_switch();
      span(1'b1, len);
      check_len(len, 41, 47);
      span(1'b0, len);
      check_len(len, 249, 256);
      on_len <= 16'h1;
      span(1'b1, len);
      check_len(len, 28, 31);
      ring_hi <= 1'b0;
      span(1'b0, len);
      check_len(len, 399, 404);
      on_len <= 16'h28;
      ring_hi <= 1'b1;
      set_fb(1'b0, 1'b0, 1'b0);
      tick(400);
      span(1'b0, len);
      check_len(len, 326, 336);
      span(1'b0, len);
      check_len(len, 326, 336);
      n_cross <= 4'h0;
      span(1'b0, len);
      check_len(len, 399, 404);
   endtask
   task automatic t_ovp();
      int n;
      logic seen;
      ring_hi <= 1'b0;
      ovp_cmd <= 1'b1;
      n = 0;
      while (latched !== 1'b1 && n < 1000) begin
         tick(1);
         n++;
      end
      check_val(latched, 8'h1);
      seen = 1'b0;
      repeat (600) begin
         tick(1);
         if (gate !== 1'b0) seen = 1'b1;
      end
      check_val(seen, 8'h0);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_start();
      t_line();
      t_valley();
      t_switch();
      t_ovp();
      tally_and_finish();
   end
endmodule
